// [common/pstc_consts.svh]
`ifndef PSTC_CONSTS_SVH
`define PSTC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// APB register byte addresses
`define PSTC_OFS_ACCESS_CTRL   12'h000
`define PSTC_OFS_DATA_LOW      12'h004
`define PSTC_OFS_DATA_HIGH     12'h008

// Reset values
`define PSTC_RST_ACCESS_CTRL   16'h0000
`define PSTC_RST_DATA_HALF     16'h0000

////////////////////////////////////////////////////////////////////////////////
// Indirect access control word layout
`define PSTC_OP_LSB            10
`define PSTC_OP_MSB            15
`define PSTC_ADDR_MSB          9
`define PSTC_OP_READ_CNT       6'h07

// Indirect counter address map
`define PSTC_PORT1_BASE        10'h000
`define PSTC_PORT2_BASE        10'h020
`define PSTC_PORT_LAST         10'h03f
`define PSTC_DROP_TX_P1        10'h100
`define PSTC_DROP_TX_P2        10'h101
`define PSTC_DROP_RX_P1        10'h103
`define PSTC_DROP_RX_P2        10'h104

// Counter word flag positions
`define PSTC_BIT_OVF           31
`define PSTC_BIT_VALID         30

////////////////////////////////////////////////////////////////////////////////
// Per-port counter offsets
`define PSTC_C_RX_OCTETS       5'h00
`define PSTC_C_RX_SHORT_OK     5'h02
`define PSTC_C_RX_SHORT_BAD    5'h03
`define PSTC_C_RX_LONG_OK      5'h04
`define PSTC_C_RX_LONG_BAD     5'h05
`define PSTC_C_RX_BAD_SYM      5'h06
`define PSTC_C_RX_CHK_FAIL     5'h07
`define PSTC_C_RX_FRAC_FAIL    5'h08
`define PSTC_C_RX_CTRL         5'h09
`define PSTC_C_RX_PAUSE        5'h0a
`define PSTC_C_RX_BCAST        5'h0b
`define PSTC_C_RX_MCAST        5'h0c
`define PSTC_C_RX_UCAST        5'h0d
`define PSTC_C_RX_BIN64        5'h0e
`define PSTC_C_RX_BIN65        5'h0f
`define PSTC_C_RX_BIN128       5'h10
`define PSTC_C_RX_BIN256       5'h11
`define PSTC_C_RX_BIN512       5'h12
`define PSTC_C_RX_BIN1024      5'h13
`define PSTC_C_TX_OCTETS       5'h14
`define PSTC_C_TX_LATE_COLL    5'h16
`define PSTC_C_TX_PAUSE        5'h17
`define PSTC_C_TX_BCAST        5'h18
`define PSTC_C_TX_MCAST        5'h19
`define PSTC_C_TX_UCAST        5'h1a
`define PSTC_C_TX_DEFER        5'h1b
`define PSTC_C_TX_ALL_COLL     5'h1c
`define PSTC_C_TX_EXCESS       5'h1d
`define PSTC_C_TX_ONE_COLL     5'h1e
`define PSTC_C_TX_MANY_COLL    5'h1f

////////////////////////////////////////////////////////////////////////////////
// Frame length limits in octets
`define PSTC_LEN_MIN           11'h040
`define PSTC_LEN_OVERSIZE      11'h600
`define PSTC_LEN_MAX           11'h77c
`define PSTC_LEN_BIN65_TOP     11'h07f
`define PSTC_LEN_BIN128_TOP    11'h0ff
`define PSTC_LEN_BIN256_TOP    11'h1ff
`define PSTC_LEN_BIN512_TOP    11'h3ff

`endif

// [common/pstc_pkg.sv]
package pstc_pkg;

    typedef enum logic [1:0] {
        PSTC_CAST_UNI   = 2'h1,
        PSTC_CAST_MULTI = 2'h2,
        PSTC_CAST_BROAD = 2'h3
    } pstc_cast_t;

    // One receive outcome per frame, qualified by done
    typedef struct packed {
        logic       done;
        logic [10:0] len;
        logic       fcs_ok;
        logic       symbol_err;
        logic       frac_byte;
        logic       mac_ctrl;
        logic       pause_fields;
        logic       low_prio;
        pstc_cast_t cast;
    } pstc_rx_rep_t;

    // One transmit outcome per frame, qualified by done
    typedef struct packed {
        logic       done;
        logic [10:0] len;
        logic       sent_ok;
        logic       pause;
        logic       low_prio;
        pstc_cast_t cast;
        logic       deferred;
        logic       late_coll;
        logic       excess_coll;
        logic [4:0] coll_cnt;
    } pstc_tx_rep_t;

    typedef struct packed {
        logic [1:0] tx;
        logic [1:0] rx;
    } pstc_drop_t;

    typedef logic [31:0][10:0] pstc_incs_t;

    typedef struct packed {
        logic [63:0][29:0] cnt;
        logic [63:0]       ovf;
        logic [3:0][15:0]  drop;
        logic [15:0]       access_ctrl;
        logic [15:0]       data_low;
        logic [15:0]       data_high;
        logic              pend;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } pstc_state_t;

endpackage : pstc_pkg

// [hdl/pstc_top.sv]
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pstc_consts.svh"
//
// Function
// - Port 1 counters at indirect 0x00-0x1f, port 2 at 0x20-0x3f, same order.
// - 0x0 sums received low-priority octets incl. bad; 0x14 good sent low-priority octets incl. pause.
// - 0x2 counts short received frames with good checksum and no symbol or alignment error.
// - 0x3 counts short frames with bad checksum, symbol or alignment error.
// - 0x4 counts received frames over 1536 bytes with good checksum and no symbol or alignment error.
// - 0x5 counts long errored frames; 0x6 legal-size frames with bad symbol.
// - 0x7 counts 64-1916 byte whole-byte frames with failing checksum.
// - 0x8 counts 64-1916 byte fractional-byte frames with failing checksum.
// - 0x9 counts every received MAC control frame.
// - 0xA counts qualified received pause frames.
// - 0xB-0xD count good broadcast, multicast, unicast; multicast excludes control.
// - 0xE-0x13 count all received frames per length bin.
// - 0x16 counts late collisions.
// - 0x17 sent pause; 0x18-0x1A good sent broadcast, multicast, unicast.
// - 0x1B counts frames whose first attempt was deferred.
// - 0x1C all collisions, 0x1D excessive, 0x1E one collision, 0x1F many.
// - Dropped-frame counters are 16 bits, no overflow or valid flags.
// - Drop counters at 0x100, 0x101 (send) and 0x103, 0x104 (receive).
// - Writing read-counter opcode plus address to control register starts a read.
// - Port counter word: overflow bit 31, valid bit 30, count 29-0.
// - Port counters clear on read; drop counters do not.
//
module pstc_top
    import pstc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire pstc_rx_rep_t [1:0] rx_rep,
    input  wire pstc_tx_rep_t [1:0] tx_rep,
    input  wire pstc_drop_t         drop_event
);

    pstc_state_t st_r;
    pstc_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Per-frame increment amounts for one port
    function automatic pstc_incs_t port_incs(input pstc_rx_rep_t rx, input pstc_tx_rep_t tx);
        pstc_incs_t  inc;
        logic        short_f;
        logic        long_f;
        logic        in_rng;
        logic        good;
        logic        bad_any;
        inc     = '0;
        short_f = rx.len < `PSTC_LEN_MIN;
        long_f  = rx.len > `PSTC_LEN_OVERSIZE;
        in_rng  = (rx.len >= `PSTC_LEN_MIN) && (rx.len <= `PSTC_LEN_MAX);
        bad_any = !rx.fcs_ok || rx.symbol_err || rx.frac_byte;
        good    = !bad_any && !short_f && !long_f;
        if (rx.done) begin
            if (rx.low_prio) begin
                inc[`PSTC_C_RX_OCTETS] = rx.len;
            end
            inc[`PSTC_C_RX_SHORT_OK]  = {10'h000, short_f && !bad_any};
            inc[`PSTC_C_RX_SHORT_BAD] = {10'h000, short_f && bad_any};
            inc[`PSTC_C_RX_LONG_OK]   = {10'h000, long_f && !bad_any};
            inc[`PSTC_C_RX_LONG_BAD]  = {10'h000, long_f && bad_any};
            inc[`PSTC_C_RX_BAD_SYM]   = {10'h000, rx.symbol_err && !short_f && !long_f};
            inc[`PSTC_C_RX_CHK_FAIL]  = {10'h000, in_rng && !rx.frac_byte && !rx.fcs_ok};
            inc[`PSTC_C_RX_FRAC_FAIL] = {10'h000, in_rng && rx.frac_byte && !rx.fcs_ok};
            inc[`PSTC_C_RX_CTRL]      = {10'h000, rx.mac_ctrl};
            inc[`PSTC_C_RX_PAUSE]     = {10'h000, rx.mac_ctrl && rx.pause_fields && !short_f
                                          && rx.fcs_ok};
            inc[`PSTC_C_RX_BCAST]     = {10'h000, good && rx.cast == PSTC_CAST_BROAD};
            inc[`PSTC_C_RX_MCAST]     = {10'h000, good && !rx.mac_ctrl
                                          && rx.cast == PSTC_CAST_MULTI};
            inc[`PSTC_C_RX_UCAST]     = {10'h000, good && rx.cast == PSTC_CAST_UNI};
            inc[`PSTC_C_RX_BIN64]     = {10'h000, rx.len == `PSTC_LEN_MIN};
            inc[`PSTC_C_RX_BIN65]     = {10'h000, rx.len > `PSTC_LEN_MIN
                                          && rx.len <= `PSTC_LEN_BIN65_TOP};
            inc[`PSTC_C_RX_BIN128]    = {10'h000, rx.len > `PSTC_LEN_BIN65_TOP
                                          && rx.len <= `PSTC_LEN_BIN128_TOP};
            inc[`PSTC_C_RX_BIN256]    = {10'h000, rx.len > `PSTC_LEN_BIN128_TOP
                                          && rx.len <= `PSTC_LEN_BIN256_TOP};
            inc[`PSTC_C_RX_BIN512]    = {10'h000, rx.len > `PSTC_LEN_BIN256_TOP
                                          && rx.len <= `PSTC_LEN_BIN512_TOP};
            inc[`PSTC_C_RX_BIN1024]   = {10'h000, rx.len > `PSTC_LEN_BIN512_TOP
                                          && rx.len <= `PSTC_LEN_MAX};
        end
        if (tx.done) begin
            if (tx.sent_ok && tx.low_prio) begin
                inc[`PSTC_C_TX_OCTETS] = tx.len;
            end
            inc[`PSTC_C_TX_LATE_COLL] = {10'h000, tx.late_coll};
            inc[`PSTC_C_TX_PAUSE]     = {10'h000, tx.sent_ok && tx.pause};
            inc[`PSTC_C_TX_BCAST]     = {10'h000, tx.sent_ok && tx.cast == PSTC_CAST_BROAD};
            inc[`PSTC_C_TX_MCAST]     = {10'h000, tx.sent_ok && tx.cast == PSTC_CAST_MULTI};
            inc[`PSTC_C_TX_UCAST]     = {10'h000, tx.sent_ok && tx.cast == PSTC_CAST_UNI};
            inc[`PSTC_C_TX_DEFER]     = {10'h000, tx.deferred};
            inc[`PSTC_C_TX_ALL_COLL]  = {6'h00, tx.coll_cnt};
            inc[`PSTC_C_TX_EXCESS]    = {10'h000, tx.excess_coll};
            inc[`PSTC_C_TX_ONE_COLL]  = {10'h000, tx.sent_ok && tx.coll_cnt == 5'h01};
            inc[`PSTC_C_TX_MANY_COLL] = {10'h000, tx.sent_ok && tx.coll_cnt > 5'h01};
        end
        return inc;
    endfunction : port_incs

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        pstc_incs_t  inc_p;
        logic [9:0]  rd_idx;
        logic        rd_port;
        logic [30:0] sum;
        logic [29:0] base;
        logic        base_ovf;
        logic [31:0] word;
        logic        hit;
        logic [31:0] rdata;
        inc_p    = '0;
        rd_idx   = st_r.access_ctrl[`PSTC_ADDR_MSB:0];
        rd_port  = st_r.pend && (rd_idx <= `PSTC_PORT_LAST);
        sum      = '0;
        base     = '0;
        base_ovf = 1'b0;
        word     = '0;
        hit      = 1'b0;
        rdata    = '0;
        st_nxt   = st_r;

        // APB: no wait states, answer registered in the setup cycle
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable && !st_r.pready) begin
            unique case (paddr)
                `PSTC_OFS_ACCESS_CTRL: begin
                    hit   = 1'b1;
                    rdata = {16'h0000, st_r.access_ctrl};
                end
                `PSTC_OFS_DATA_LOW: begin
                    hit   = 1'b1;
                    rdata = {16'h0000, st_r.data_low};
                end
                `PSTC_OFS_DATA_HIGH: begin
                    hit   = 1'b1;
                    rdata = {16'h0000, st_r.data_high};
                end
                default: begin
                    hit   = 1'b0;
                    rdata = '0;
                end
            endcase
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !hit || (pwrite && paddr != `PSTC_OFS_ACCESS_CTRL);
            st_nxt.prdata  = pwrite ? 32'h0000_0000 : rdata;
        end

        // Snapshot of the addressed counter, one cycle after the command
        if (st_r.pend) begin
            if (rd_port) begin
                word = {st_r.ovf[rd_idx[5:0]], 1'b1, st_r.cnt[rd_idx[5:0]]};
            end else begin
                unique case (rd_idx)
                    `PSTC_DROP_TX_P1: word = {16'h0000, st_r.drop[0]};
                    `PSTC_DROP_TX_P2: word = {16'h0000, st_r.drop[1]};
                    `PSTC_DROP_RX_P1: word = {16'h0000, st_r.drop[2]};
                    `PSTC_DROP_RX_P2: word = {16'h0000, st_r.drop[3]};
                    default:          word = '0;
                endcase
            end
            st_nxt.data_low  = word[15:0];
            st_nxt.data_high = word[31:16];
            st_nxt.pend      = 1'b0;
        end

        // Command write; valid reads zero until the snapshot lands
        if (psel && penable && st_r.pready && pwrite && paddr == `PSTC_OFS_ACCESS_CTRL) begin
            st_nxt.access_ctrl = pwdata[15:0];
            st_nxt.data_low    = `PSTC_RST_DATA_HALF;
            st_nxt.data_high   = `PSTC_RST_DATA_HALF;
            st_nxt.pend        = pwdata[`PSTC_OP_MSB:`PSTC_OP_LSB] == `PSTC_OP_READ_CNT;
        end

        // Per-port counters; a frame in the clearing cycle is kept
        for (int p = 0; p < 2; p++) begin
            inc_p = port_incs(rx_rep[p], tx_rep[p]);
            for (int k = 0; k < 32; k++) begin
                if (rd_port && rd_idx[5:0] == 6'(p * 32 + k)) begin
                    base     = '0;
                    base_ovf = 1'b0;
                end else begin
                    base     = st_r.cnt[p * 32 + k];
                    base_ovf = st_r.ovf[p * 32 + k];
                end
                sum = {1'b0, base} + {20'h00000, inc_p[k]};
                st_nxt.cnt[p * 32 + k] = sum[29:0];
                st_nxt.ovf[p * 32 + k] = base_ovf || sum[30];
            end
        end

        // Drop counters wrap and are never cleared by reads
        st_nxt.drop[0] = st_r.drop[0] + {15'h0000, drop_event.tx[0]};
        st_nxt.drop[1] = st_r.drop[1] + {15'h0000, drop_event.tx[1]};
        st_nxt.drop[2] = st_r.drop[2] + {15'h0000, drop_event.rx[0]};
        st_nxt.drop[3] = st_r.drop[3] + {15'h0000, drop_event.rx[1]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r             <= '0;
            st_r.access_ctrl <= `PSTC_RST_ACCESS_CTRL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;

endmodule : pstc_top

// [verification/pstc_monitor.sv]
`timescale 1ns/1ps
module pstc_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    logic [9:0] cmd_r;
    logic       cmd_ok_r;
    logic [1:0] age_r;
    logic       ctl_wr;
    logic       setup;
    logic       rd_high;
    assign ctl_wr  = psel && penable && pready && pwrite && paddr == 12'h000;
    assign setup   = psel && !penable;
    assign rd_high = setup && !pwrite && paddr == 12'h008;
    // Last indirect command and cycles since it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_r    <= 10'h000;
            cmd_ok_r <= 1'b0;
            age_r    <= 2'h0;
        end else if (ctl_wr) begin
            cmd_r    <= pwdata[9:0];
            cmd_ok_r <= pwdata[15:10] == 6'h07;
            age_r    <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rdy; setup |=> pready && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready in access cycle");
    property p_rdy1; pready |=> !pready; endproperty
    a_rdy1: assert property (p_rdy1) else $error("pready longer than one cycle");
    property p_gate; pready |-> psel && penable; endproperty
    a_gate: assert property (p_gate) else $error("pready outside access");
    property p_map; setup && !(paddr inside {12'h000, 12'h004, 12'h008}) |=> pslverr && prdata == 32'h0; endproperty
    a_map: assert property (p_map) else $error("unmapped access not refused");
    property p_ro; setup && pwrite && paddr inside {12'h004, 12'h008} |=> pslverr; endproperty
    a_ro: assert property (p_ro) else $error("data half write not refused");
    property p_ctl; setup && paddr == 12'h000 |=> !pslverr; endproperty
    a_ctl: assert property (p_ctl) else $error("control access refused");
    property p_fresh; ctl_wr ##1 rd_high |=> !prdata[14]; endproperty
    a_fresh: assert property (p_fresh) else $error("valid set right after command");
    property p_vld; rd_high && cmd_ok_r && cmd_r < 10'h040 && age_r != 2'h0 |=> prdata[14]; endproperty
    a_vld: assert property (p_vld) else $error("port counter not valid");
    property p_drop; rd_high && cmd_ok_r && cmd_r >= 10'h040 |=> prdata == 32'h0; endproperty
    a_drop: assert property (p_drop) else $error("drop word upper half not zero");
    property p_top; pready && !pwrite |-> prdata[31:16] == 16'h0; endproperty
    a_top: assert property (p_top) else $error("read data above bit 15 set");
    property p_op; setup && !pwrite && paddr inside {12'h004, 12'h008} && !cmd_ok_r |=> prdata == 32'h0; endproperty
    a_op: assert property (p_op) else $error("data without read command");
    c_fresh: cover property (ctl_wr ##1 rd_high);
    c_err: cover property (pready && pslverr);
    c_vld: cover property (rd_high && age_r != 2'h0);
endmodule : pstc_monitor

bind pstc_top pstc_monitor i_pstc_monitor (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [verification/pstc_host_model.sv]
`timescale 1ns/1ps
module pstc_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end
    // Entered just after an edge; bus stays held so a setup may follow at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
    endtask : apb
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : idle
    task automatic read_counter(input logic [9:0] a, output logic [31:0] w);
        logic [31:0] hi;
        logic [31:0] lo;
        logic        e;
        @(posedge clk);
        apb(1'b1, 12'h000, {16'h0, 6'h07, a}, lo, e);
        apb(1'b0, 12'h008, 32'h0, hi, e);
        while (a < 10'h040 && hi[14] !== 1'b1) begin
            apb(1'b0, 12'h008, 32'h0, hi, e);
        end
        apb(1'b0, 12'h004, 32'h0, lo, e);
        idle();
        w = {hi[15:0], lo[15:0]};
    endtask : read_counter
endmodule : pstc_host_model

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench
    import pstc_pkg::*;
;
    logic               clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata;
    pstc_rx_rep_t [1:0] rx_rep;
    pstc_tx_rep_t [1:0] tx_rep;
    pstc_drop_t         drop_event;
    int                 n_errors, tests_run, cycles;
    // Counter address in [27:16], expected count in [15:0]
    localparam logic [31:0] TBL [38] = '{
        32'h0000_1b20, 32'h0002_0001, 32'h0003_0001, 32'h0004_0001, 32'h0005_0002, 32'h0006_0001,
        32'h0007_0001, 32'h0008_0001, 32'h0009_0001, 32'h000a_0001, 32'h000b_0001, 32'h000c_0000,
        32'h000d_0002, 32'h000e_0001, 32'h000f_0001, 32'h0010_0001, 32'h0013_0004, 32'h0022_0001,
        32'h0020_003c, 32'h000e_0000, 32'h0034_016c, 32'h0036_0001, 32'h0037_0001, 32'h0038_0001,
        32'h0039_0001, 32'h003a_0001, 32'h003b_0001, 32'h003c_0014, 32'h003d_0001, 32'h003e_0001,
        32'h003f_0001, 32'h0014_0000, 32'h0100_0002, 32'h0100_0002, 32'h0101_0000, 32'h0103_0000,
        32'h0104_0001, 32'h0102_0000};

    pstc_top i_pstc_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_rep(rx_rep), .tx_rep(tx_rep), .drop_event(drop_event));
    pstc_host_model i_pstc_host_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rx(input int p, input logic [10:0] l, input logic [4:0] f, input pstc_cast_t c);
        @(posedge clk);
        rx_rep[p] <= {1'b1, l, f, 1'b1, c};
        @(posedge clk);
        rx_rep[p] <= '0;
    endtask : rx
    task automatic tx(input int p, input logic [10:0] l, input logic [1:0] sp, input pstc_cast_t c,
                      input logic [2:0] dlx, input logic [4:0] n);
        @(posedge clk);
        tx_rep[p] <= {1'b1, l, sp, 1'b1, c, dlx, n};
        @(posedge clk);
        tx_rep[p] <= '0;
    endtask : tx
    task automatic check_table(input int lo, input int hi);
        logic [31:0] w;
        logic [31:0] x;
        for (int i = lo; i < hi; i++) begin
            x = TBL[i];
            i_pstc_host_model.read_counter(x[25:16], w);
            chk($sformatf("ctr_%h", x[27:16]),
                x[27:16] < 12'h040 ? {2'b01, 14'h0, x[15:0]} : {16'h0, x[15:0]}, w);
        end
    endtask : check_table
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        @(posedge clk);
        i_pstc_host_model.apb(1'b0, 12'h000, 32'h0, r, e);
        chk("ctrl_reset", 32'h0, r);
        i_pstc_host_model.apb(1'b0, 12'h004, 32'h0, r, e);
        chk("low_reset", 32'h0, r);
        i_pstc_host_model.apb(1'b1, 12'h008, 32'h1234, r, e);
        chk("ro_err", 32'h1, {31'h0, e});
        i_pstc_host_model.apb(1'b0, 12'h00c, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        i_pstc_host_model.apb(1'b1, 12'h000, 32'h0c0e, r, e);
        i_pstc_host_model.apb(1'b0, 12'h000, 32'h0, r, e);
        chk("ctrl_rw", 32'h0c0e, r);
        i_pstc_host_model.apb(1'b0, 12'h008, 32'h0, r, e);
        chk("other_op", 32'h0, r);
        i_pstc_host_model.idle();
    endtask : t_regs
    task automatic t_rx();
        rx(0, 11'h040, 5'h10, PSTC_CAST_UNI);
        rx(0, 11'h03f, 5'h10, PSTC_CAST_UNI);
        rx(0, 11'h03f, 5'h00, PSTC_CAST_UNI);
        rx(0, 11'h601, 5'h10, PSTC_CAST_UNI);
        rx(0, 11'h601, 5'h00, PSTC_CAST_UNI);
        rx(0, 11'h77c, 5'h04, PSTC_CAST_UNI);
        rx(0, 11'h064, 5'h13, PSTC_CAST_MULTI);
        rx(0, 11'h080, 5'h18, PSTC_CAST_UNI);
        rx(0, 11'h600, 5'h10, PSTC_CAST_BROAD);
        rx(1, 11'h03c, 5'h10, PSTC_CAST_UNI);
        // High-priority frame: unicast counted, octets not
        @(posedge clk);
        rx_rep[0] <= {1'b1, 11'h100, 5'h10, 1'b0, PSTC_CAST_UNI};
        @(posedge clk);
        rx_rep[0] <= '0;
        check_table(0, 20);
    endtask : t_rx
    task automatic t_tx();
        tx(1, 11'h040, 2'h3, PSTC_CAST_MULTI, 3'h0, 5'h00);
        tx(1, 11'h064, 2'h2, PSTC_CAST_BROAD, 3'h4, 5'h01);
        tx(1, 11'h0c8, 2'h2, PSTC_CAST_UNI, 3'h0, 5'h03);
        tx(1, 11'h12c, 2'h0, PSTC_CAST_UNI, 3'h3, 5'h10);
        check_table(20, 32);
    endtask : t_tx
    task automatic t_drop();
        @(posedge clk);
        drop_event <= 4'h4;
        @(posedge clk);
        drop_event <= 4'h6;
        @(posedge clk);
        drop_event <= '0;
        check_table(32, 38);
    endtask : t_drop
    initial begin
        rst_n = 1'b0;
        rx_rep = '0;
        tx_rep = '0;
        drop_event = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_rx();
        t_tx();
        t_drop();
        results();
    end
endmodule : testbench
